/* hdl/pbs_defs.svh */
// Constants for the pipelined burst SRAM port
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH
`define PBS_ADDR_W 6
`define PBS_LANES 4
`define PBS_DATA_W 32
`define PBS_WORD_W 36
`define PBS_PAR_LSB 32
`define PBS_LANES_OFF 4'hF
`define PBS_FIFO_DEPTH 16
`define PBS_FIFO_W (`PBS_ADDR_W + `PBS_LANES + `PBS_WORD_W)
`define PBS_CLK_NS 4
`define PBS_SLEEP_NS 8
`define PBS_SLEEP_CYC ((`PBS_SLEEP_NS + `PBS_CLK_NS - 1) / `PBS_CLK_NS)
`endif

/* hdl/pbs_pkg.sv */
// Types shared by the burst SRAM port modules
package pbs_pkg;
  typedef enum logic [1:0] {
    PBS_OP_IDLE  = 2'b00,
    PBS_OP_READ  = 2'b01,
    PBS_OP_WRITE = 2'b10
  } pbs_op_type;
endpackage

/* hdl/pbs_fifo_if.sv */
// Carrier between the port logic and its write buffer
`timescale 1ns/1ps
interface pbs_fifo_if #(parameter int WIDTH = 8);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic full;
  modport fill (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, full);
  modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, full);
endinterface

/* hdl/pbs_fifo.sv */
// Write buffer FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input logic clk_i,
  input logic rst_i,
  pbs_fifo_if.store bus
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  // Handshakes; full and empty follow the fill count
  assign bus.full = (count_r == PW'(0) + (PW+1)'(DEPTH));
  assign bus.in_ready = ~bus.full;
  assign bus.out_valid = (count_r != '0);
  assign bus.out_data = store_r[rd_ptr_r];
  assign push = bus.in_valid & bus.in_ready;
  assign pop = bus.out_valid & bus.out_ready;

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      store_r[wr_ptr_r] <= bus.in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + (PW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (PW+1)'(1);
      end
    end
  end
endmodule

/* hdl/pbs_sram_port.sv */
// Pipelined burst SRAM synchronous port with byte writes and sleep
//
// Overview of operation
// - Write start latches address and write controls
// - Lanes float the edge after write start
// - Next command accepted during write data phase
// - Write data captured second edge after command
// - Only selected byte lanes are updated
// - One address loads four beats, then the burst order wraps to the first
// - Advance ignores selects, bumps burst counter
// - Sleep asynchronous, two cycles in/out
// - Sleep voids pending accesses, lanes float
// - Interleaved order is start XOR count
// - Linear order adds count modulo four
// - Read start; drive only with enable low
// - Advance keeps burst type, next address
// - All byte selects high aborts write
// - Clock hold ignores the edge, except in the sleep and order sync flops and the buffer-full flag
// - Any write cycle floats all lanes
// - Power-up deselected with lanes floating
// - Output enable combinational, masked on writes
// - Read data one edge after command
// - Deselect floats outputs after next edge
// - Write strobe sampled only at burst start
`timescale 1ns/1ps
`include "pbs_defs.svh"
module pbs_sram_port
  import pbs_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic [`PBS_ADDR_W-1:0] address_i,
  input logic chip_select_a_n_i,
  input logic chip_select_b_i,
  input logic chip_select_c_n_i,
  input logic write_strobe_n_i,
  input logic [`PBS_LANES-1:0] byte_lane_select_n_i,
  input logic advance_or_load_i,
  input logic clock_hold_n_i,
  input logic burst_order_i,
  input logic sleep_request_i,
  input logic output_enable_n_i,
  input logic [`PBS_DATA_W-1:0] dq_i,
  input logic [`PBS_LANES-1:0] parity_lanes_i,
  output logic [`PBS_DATA_W-1:0] dq_o,
  output logic [`PBS_LANES-1:0] parity_lanes_o,
  output logic dq_oe_o,
  output logic sleep_active_o,
  output logic wr_buffer_full_o
);
  localparam int AW = `PBS_ADDR_W;
  localparam int SYNC = `PBS_SLEEP_CYC;

  logic [`PBS_WORD_W-1:0] mem_r [1 << AW];
  logic [SYNC-1:0] sleep_sync_r;
  logic [1:0] order_sync_r;
  logic asleep;
  logic interleave;
  logic go;
  logic cs_all;
  logic burst_on_r;
  logic burst_wr_r;
  logic [AW-1:0] base_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] low_nxt;
  pbs_op_type op1_r;
  logic [AW-1:0] addr1_r;
  logic [`PBS_LANES-1:0] be1_n_r;
  logic wr2_on_r;
  logic [AW-1:0] addr2_r;
  logic [`PBS_LANES-1:0] be2_n_r;
  logic drive_r;
  logic [`PBS_WORD_W-1:0] out_r;
  logic buf_full_r;
  logic [AW-1:0] pop_addr;
  logic [`PBS_LANES-1:0] pop_be_n;
  logic [`PBS_WORD_W-1:0] pop_word;
  logic pop_fire;

  pbs_fifo_if #(.WIDTH(`PBS_FIFO_W)) wbuf ();

  pbs_fifo #(
    .WIDTH(`PBS_FIFO_W),
    .DEPTH(`PBS_FIFO_DEPTH)
  ) u_wbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(wbuf)
  );

  // Sleep request and order strap are asynchronous; two flops each
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_sync_r <= '0;
      order_sync_r <= 2'h0;
    end else begin
      sleep_sync_r <= {sleep_sync_r[SYNC-2:0], sleep_request_i};
      order_sync_r <= {order_sync_r[0], burst_order_i};
    end
  end

  // Last sync stage is the sleep state: entry and exit both take two edges
  assign asleep = sleep_sync_r[SYNC-1];
  assign interleave = order_sync_r[1];
  assign go = ~clock_hold_n_i & ~asleep;
  assign cs_all = ~chip_select_a_n_i & chip_select_b_i & ~chip_select_c_n_i;

  // Next burst beat: only the two low bits move
  assign cnt_nxt = cnt_r + 2'h1;
  assign low_nxt = interleave ? (base_r[1:0] ^ cnt_nxt) : (base_r[1:0] + cnt_nxt);

  // Burst state; strobe sampled only when a burst loads
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_on_r <= 1'b0;
      burst_wr_r <= 1'b0;
      base_r <= '0;
      cnt_r <= 2'h0;
    end else if (asleep) begin
      burst_on_r <= 1'b0;
    end else if (go) begin
      if (!advance_or_load_i) begin
        burst_on_r <= cs_all;
        if (cs_all) begin
          base_r <= address_i;
          burst_wr_r <= ~write_strobe_n_i;
          cnt_r <= 2'h0;
        end
      end else if (burst_on_r) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // Command stage: operation, address and byte selects of this edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      op1_r <= PBS_OP_IDLE;
      addr1_r <= '0;
      be1_n_r <= `PBS_LANES_OFF;
    end else if (asleep) begin
      op1_r <= PBS_OP_IDLE;
    end else if (go) begin
      be1_n_r <= byte_lane_select_n_i;
      if (!advance_or_load_i) begin
        addr1_r <= address_i;
        if (!cs_all) begin
          op1_r <= PBS_OP_IDLE;
        end else if (write_strobe_n_i) begin
          op1_r <= PBS_OP_READ;
        end else begin
          op1_r <= PBS_OP_WRITE;
        end
      end else begin
        addr1_r <= {base_r[AW-1:2], low_nxt};
        if (!burst_on_r) begin
          op1_r <= PBS_OP_IDLE;
        end else begin
          op1_r <= burst_wr_r ? PBS_OP_WRITE : PBS_OP_READ;
        end
      end
    end
  end

  // Data stage: read fetch or write data phase, new command taken meanwhile
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_r <= 1'b0;
      out_r <= '0;
      wr2_on_r <= 1'b0;
      addr2_r <= '0;
      be2_n_r <= `PBS_LANES_OFF;
    end else if (asleep) begin
      drive_r <= 1'b0;
      wr2_on_r <= 1'b0;
    end else if (go) begin
      drive_r <= (op1_r == PBS_OP_READ);
      wr2_on_r <= (op1_r == PBS_OP_WRITE);
      addr2_r <= addr1_r;
      be2_n_r <= be1_n_r;
      if (op1_r == PBS_OP_READ) begin
        out_r <= mem_r[addr1_r];
      end
    end
  end

  // Write data is pushed to the buffer on the second edge; aborted beats push nothing
  assign wbuf.in_valid = go & wr2_on_r & (be2_n_r != `PBS_LANES_OFF);
  assign wbuf.in_data = {addr2_r, be2_n_r, parity_lanes_i, dq_i};

  // Drain stalls under clock hold and sleep; pushes stall with it, so
  // at most one word waits and a read right after a write sees old data
  assign wbuf.out_ready = go;
  assign {pop_addr, pop_be_n, pop_word} = wbuf.out_data;
  assign pop_fire = wbuf.out_valid & wbuf.out_ready;

  // Array commit, masked per lane; storage holds through sleep
  always_ff @(posedge clk_i) begin
    if (pop_fire) begin
      for (int i = 0; i < `PBS_LANES; i++) begin
        if (!pop_be_n[i]) begin
          mem_r[pop_addr][i*8 +: 8] <= pop_word[i*8 +: 8];
          mem_r[pop_addr][`PBS_PAR_LSB + i] <= pop_word[`PBS_PAR_LSB + i];
        end
      end
    end
  end

  // A full buffer drops the write; flagged so the controller can back off
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      buf_full_r <= 1'b0;
    end else begin
      buf_full_r <= wbuf.full;
    end
  end

  // Output enable is not sampled: the enable path stays combinational
  // Sleep also masks it, in case a read was in flight when sleep began
  assign dq_oe_o = drive_r & ~asleep & ~output_enable_n_i;
  assign dq_o = out_r[`PBS_DATA_W-1:0];
  assign parity_lanes_o = out_r[`PBS_WORD_W-1:`PBS_PAR_LSB];
  assign sleep_active_o = asleep;
  assign wr_buffer_full_o = buf_full_r;

  // Checks
  sequence s_wr_start;
    go && !advance_or_load_i && cs_all && !write_strobe_n_i;
  endsequence

  sequence s_rd_start;
    go && !advance_or_load_i && cs_all && write_strobe_n_i;
  endsequence

  sequence s_advance;
    go && advance_or_load_i && burst_on_r;
  endsequence

  // Deselect taken on a load edge
  sequence s_deselect;
    go && !advance_or_load_i && !cs_all;
  endsequence

  // Sleep request seen on two edges in a row
  sequence s_sleep_in;
    sleep_request_i [*2];
  endsequence

  // Sleep request low on two edges in a row
  sequence s_wake_in;
    !sleep_request_i [*2];
  endsequence

  AST_WRITE_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_start |=> (op1_r == PBS_OP_WRITE) && (addr1_r == $past(address_i)))
    else $error("write start not latched");

  AST_WRITE_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_start ##1 go |=> !dq_oe_o)
    else $error("lanes driven during write data phase");

  AST_BACK_TO_BACK: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wr_start ##1 s_rd_start |=> (op1_r == PBS_OP_READ) && wr2_on_r)
    else $error("command lost during write data phase");

  AST_DATA_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_wr_start and (byte_lane_select_n_i != `PBS_LANES_OFF)) ##1 go ##1 go
    |-> wbuf.in_valid && (wbuf.in_data[`PBS_DATA_W-1:0] == dq_i))
    else $error("write data not captured on second edge");

  AST_LANE_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    pop_fire && pop_be_n[0] |=> mem_r[$past(pop_addr)][7:0] == $past(mem_r[pop_addr][7:0]))
    else $error("unselected lane changed");

  AST_BURST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    s_advance |=> cnt_r == $past(cnt_nxt))
    else $error("burst counter did not advance");

  AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sleep_in |=> asleep)
    else $error("sleep not entered after two edges");

  AST_SLEEP_EXIT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wake_in |=> !asleep)
    else $error("sleep not left after two edges");

  AST_SLEEP_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep |-> !dq_oe_o && !wbuf.in_valid)
    else $error("activity while asleep");

  AST_INTERLEAVE: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_advance and interleave) |=> addr1_r[1:0] == ($past(base_r[1:0]) ^ $past(cnt_nxt)))
    else $error("interleaved order wrong");

  AST_LINEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_advance and !interleave) |=> addr1_r[1:0] == ($past(base_r[1:0]) + $past(cnt_nxt)))
    else $error("linear order wrong");

  AST_KEEP_TYPE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_advance |=> op1_r == (burst_wr_r ? PBS_OP_WRITE : PBS_OP_READ))
    else $error("burst type changed");

  AST_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
    wr2_on_r && (be2_n_r == `PBS_LANES_OFF) |-> !wbuf.in_valid && !dq_oe_o)
    else $error("aborted write had effect");

  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_hold_n_i && !asleep |=> $stable(op1_r) && $stable(cnt_r) && $stable(drive_r))
    else $error("state moved on a held edge");

  AST_READ_LATENCY: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_start ##1 go |=> drive_r && (out_r == $past(mem_r[addr1_r])))
    else $error("read data late or wrong");

  AST_DESELECT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_deselect ##1 go |=> !drive_r)
    else $error("outputs not released after deselect");

  AST_UPPER_FIXED: assert property (@(posedge clk_i) disable iff (rst_i)
    s_advance |=> addr1_r[AW-1:2] == $past(base_r[AW-1:2]))
    else $error("burst changed upper address bits");

  AST_POWER_UP: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> !dq_oe_o && !sleep_active_o && (op1_r == PBS_OP_IDLE))
    else $error("not deselected after power-up");

  AST_TYPE_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    s_advance |=> $stable(burst_wr_r))
    else $error("burst type relatched on an advance");

  AST_SLEEP_VOID: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep |=> (op1_r == PBS_OP_IDLE) && !wr2_on_r && !burst_on_r)
    else $error("access pending across sleep");

  AST_WRITE_MASK: assert property (@(posedge clk_i) disable iff (rst_i)
    wr2_on_r |-> !dq_oe_o)
    else $error("lanes driven in a write cycle");

  AST_NO_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
    wbuf.in_valid |-> wbuf.in_ready)
    else $error("write data refused by the buffer");

  AST_HOLD_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
    clock_hold_n_i && !asleep |=> $stable(out_r) && $stable(wr2_on_r) && $stable(burst_on_r))
    else $error("data stage moved on a held edge");

  AST_OE_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
    drive_r && !asleep |-> dq_oe_o == !output_enable_n_i)
    else $error("output enable not applied at once");
endmodule

/* dv/pbs_ctrl_model.sv */
// Memory controller model that drives the burst SRAM port pins
`timescale 1ns/1ps
`include "pbs_defs.svh"
module pbs_ctrl_model (
  input wire logic clk_i,
  output logic [`PBS_ADDR_W-1:0] address_o,
  output logic chip_select_a_n_o,
  output logic chip_select_b_o,
  output logic chip_select_c_n_o,
  output logic write_strobe_n_o,
  output logic [`PBS_LANES-1:0] byte_lane_select_n_o,
  output logic advance_or_load_o,
  output logic clock_hold_n_o,
  output logic burst_order_o,
  output logic sleep_request_o,
  output logic output_enable_n_o,
  output logic [`PBS_DATA_W-1:0] dq_o,
  output logic [`PBS_LANES-1:0] parity_lanes_o
);
  localparam int K_IDLE = 0, K_RD = 1, K_WR = 2, K_ADV = 3, K_HOLD = 4;
  logic [36:0] slot0;
  logic [36:0] slot1;
  logic burst_wr;
  // Deselected and quiet from time zero
  initial begin
    {address_o, dq_o, parity_lanes_o} = '0;
    {chip_select_a_n_o, chip_select_b_o, chip_select_c_n_o} = 3'b101;
    {write_strobe_n_o, byte_lane_select_n_o, advance_or_load_o} = 6'h3E;
    {clock_hold_n_o, burst_order_o, sleep_request_o, output_enable_n_o} = 4'h4;
    slot0 = '0;
    slot1 = '0;
    burst_wr = 1'b0;
  end
  // One cycle after a falling edge; write data leaves two cycles later
  task automatic cycle(input int kind, input logic [5:0] a, input logic [3:0] bw,
                       input logic [35:0] d);
    logic sel;
    @(negedge clk_i);
    sel = (kind == K_RD) || (kind == K_WR);
    if (sel) begin
      burst_wr = (kind == K_WR);
    end
    clock_hold_n_o = (kind == K_HOLD);
    advance_or_load_o = (kind == K_ADV);
    // Advance beats show wrong selects, strobe and address on purpose
    {chip_select_a_n_o, chip_select_b_o, chip_select_c_n_o} = sel ? 3'b010 : 3'b101;
    write_strobe_n_o = !((kind == K_WR) || (kind == K_ADV && !burst_wr));
    address_o = (kind == K_ADV) ? ~a : a;
    byte_lane_select_n_o = bw;
    if (kind != K_HOLD) begin
      // Lanes carry data only in a write slot, else a changing pattern
      {parity_lanes_o, dq_o} = slot1[36] ? slot1[35:0] : ~{parity_lanes_o, dq_o};
      slot1 = slot0;
      slot0 = {(kind == K_WR) || (kind == K_ADV && burst_wr), d};
    end
  endtask
  // Slow pins, changed at once when called; no clock edge is waited for
  task automatic set_pins(input logic slp, input logic ord, input logic oe_n);
    sleep_request_o = slp;
    burst_order_o = ord;
    output_enable_n_o = oe_n;
  endtask
endmodule

/* dv/pbs_sram_port_test.sv */
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
`include "pbs_defs.svh"
module pbs_sram_port_test;
  localparam int K_IDLE = 0, K_RD = 1, K_WR = 2, K_ADV = 3, K_HOLD = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] addr;
  logic cs_a_n, cs_b, cs_c_n, we_n, adv, hold, order, sleep, oe_n;
  logic [3:0] bw_n, par_w, parity_lanes_o;
  logic [31:0] dq_w, dq_o;
  logic dq_oe_o, sleep_active_o, wr_buffer_full_o;
  logic [35:0] mem [0:63];
  int num_errors = 0;
  int num_checks = 0;
  // Free-running 250 MHz clock
  always #2 clk_i = ~clk_i;
  pbs_ctrl_model i_ctrl (.clk_i(clk_i), .address_o(addr), .chip_select_a_n_o(cs_a_n),
    .chip_select_b_o(cs_b), .chip_select_c_n_o(cs_c_n), .write_strobe_n_o(we_n),
    .byte_lane_select_n_o(bw_n), .advance_or_load_o(adv), .clock_hold_n_o(hold),
    .burst_order_o(order), .sleep_request_o(sleep), .output_enable_n_o(oe_n),
    .dq_o(dq_w), .parity_lanes_o(par_w));
  pbs_sram_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .address_i(addr),
    .chip_select_a_n_i(cs_a_n), .chip_select_b_i(cs_b), .chip_select_c_n_i(cs_c_n),
    .write_strobe_n_i(we_n), .byte_lane_select_n_i(bw_n), .advance_or_load_i(adv),
    .clock_hold_n_i(hold), .burst_order_i(order), .sleep_request_i(sleep),
    .output_enable_n_i(oe_n), .dq_i(dq_w), .parity_lanes_i(par_w), .dq_o(dq_o),
    .parity_lanes_o(parity_lanes_o), .dq_oe_o(dq_oe_o), .sleep_active_o(sleep_active_o),
    .wr_buffer_full_o(wr_buffer_full_o));
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Burst address of beat k; only the two low bits move
  function automatic logic [5:0] baddr(input logic [5:0] b, input logic ord, input int k);
    return ord ? {b[5:2], b[1:0] ^ 2'(k)} : {b[5:2], b[1:0] + 2'(k)};
  endfunction
  function automatic logic [35:0] pat(input logic [5:0] a, input int k);
    return {4'(k + 1), 24'hC3A500, 2'b00, a};
  endfunction
  task automatic idle(input int n);
    repeat (n) i_ctrl.cycle(K_IDLE, 6'h00, 4'hF, '0);
  endtask
  task automatic wr(input logic [5:0] a, input logic [3:0] bw, input logic [35:0] d);
    i_ctrl.cycle(K_WR, a, bw, d);
    for (int i = 0; i < 4; i++) begin
      if (!bw[i]) begin
        mem[a][8*i+:8] = d[8*i+:8];
        mem[a][32+i] = d[32+i];
      end
    end
  endtask
  task automatic rd_chk(input logic [5:0] a);
    i_ctrl.cycle(K_RD, a, 4'hF, '0);
    idle(2);
    chk_word({parity_lanes_o, dq_o}, mem[a]);
    chk_bit(dq_oe_o, 1'b1);
    idle(1);
    chk_bit(dq_oe_o, 1'b0);
  endtask
  task automatic t_reset();
    chk_bit(dq_oe_o, 1'b0);
    chk_bit(sleep_active_o, 1'b0);
    chk_bit(wr_buffer_full_o, 1'b0);
  endtask
  task automatic t_write_read();
    wr(6'h05, 4'h0, 36'h9_1234_5678);
    idle(3);
    rd_chk(6'h05);
    i_ctrl.cycle(K_RD, 6'h05, 4'hF, '0);
    idle(2);
    i_ctrl.set_pins(1'b0, 1'b1, 1'b1);
    #1 chk_bit(dq_oe_o, 1'b0);
    i_ctrl.set_pins(1'b0, 1'b1, 1'b0);
    #0.5 chk_bit(dq_oe_o, 1'b1);
    idle(1);
  endtask
  // Read, write and read on consecutive edges
  task automatic t_b2b();
    i_ctrl.cycle(K_RD, 6'h05, 4'hF, '0);
    wr(6'h06, 4'h0, 36'h3_CAFE_0001);
    i_ctrl.cycle(K_RD, 6'h05, 4'hF, '0);
    chk_bit(dq_oe_o, 1'b1);
    idle(1);
    chk_bit(dq_oe_o, 1'b0);
    idle(1);
    chk_word({parity_lanes_o, dq_o}, mem[5]);
    idle(3);
    rd_chk(6'h06);
  endtask
  task automatic t_bytes();
    wr(6'h09, 4'h0, 36'h1_1111_1111);
    wr(6'h09, 4'h5, 36'hE_EEEE_EEEE);
    wr(6'h09, 4'hF, 36'h7_7777_7777);
    chk_bit(wr_buffer_full_o, 1'b0);
    idle(3);
    rd_chk(6'h09);
  endtask
  task automatic t_burst(input logic ord, input logic [5:0] b);
    i_ctrl.set_pins(1'b0, ord, 1'b0);
    idle(3);
    for (int k = 0; k < 4; k++) begin
      i_ctrl.cycle(k == 0 ? K_WR : K_ADV, b, 4'h0, pat(baddr(b, ord, k), k));
      mem[baddr(b, ord, k)] = pat(baddr(b, ord, k), k);
    end
    idle(3);
    for (int k = 0; k < 6; k++) begin
      i_ctrl.cycle(k == 0 ? K_RD : (k < 4 ? K_ADV : K_IDLE), b, 4'hF, '0);
      if (k >= 2) chk_word({parity_lanes_o, dq_o}, mem[baddr(b, ord, k - 2)]);
    end
  endtask
  // Held edges freeze the read pipeline and the pending deselect
  task automatic t_stall();
    i_ctrl.cycle(K_RD, 6'h05, 4'hF, '0);
    i_ctrl.cycle(K_HOLD, 6'h00, 4'hF, '0);
    idle(1);
    chk_bit(dq_oe_o, 1'b0);
    i_ctrl.cycle(K_HOLD, 6'h00, 4'hF, '0);
    chk_word({parity_lanes_o, dq_o}, mem[5]);
    idle(1);
    chk_bit(dq_oe_o, 1'b1);
    idle(1);
    chk_bit(dq_oe_o, 1'b0);
  endtask
  task automatic t_sleep();
    wr(6'h0C, 4'h0, 36'hA_0BAD_F00D);
    idle(3);
    i_ctrl.set_pins(1'b1, 1'b1, 1'b0);
    idle(1);
    chk_bit(sleep_active_o, 1'b0);
    idle(1);
    chk_bit(sleep_active_o, 1'b1);
    i_ctrl.cycle(K_RD, 6'h0C, 4'hF, '0);
    idle(2);
    chk_bit(dq_oe_o, 1'b0);
    i_ctrl.set_pins(1'b0, 1'b1, 1'b0);
    idle(1);
    chk_bit(sleep_active_o, 1'b1);
    idle(1);
    chk_bit(sleep_active_o, 1'b0);
    idle(2);
    rd_chk(6'h0C);
  endtask
  // Cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_write_read();
    t_b2b();
    t_bytes();
    t_burst(1'b1, 6'h11);
    t_burst(1'b0, 6'h21);
    t_stall();
    t_sleep();
    complete_run();
  end
endmodule
